/* File: design/mfi_input_actions.sv */
/*
 Dispatcher from the setting codes of the digital input terminals to
 actions on the motor output stage, with a classic Wishbone slave.
 Assumes terminal levels already debounced and synchronous to core_clk,
 and a ramp generator and output stage that obey the action outputs.
*/
// Operation
// - External fault stops per method, latches until reset
// - Coast input cuts output, shows coast indication
// - Pause coasts, waits, restarts on release
// - Linear ramps while on, auto ramp off
// - Force analog source, input one wins
// - Force stop ramps or coasts per stop method
// - Up/down activation steps frequency one unit
// - Held up/down keeps stepping at rates
// - Frequency clears when stopped at zero
// - Options bit seven drops retained frequency
// - PID disabled while input on
// - Clear input zeroes and holds counter
// - Counter pulses count, compare with target
// - Jog inputs honoured only from terminals
// - Jog in torque mode forces speed mode
`include "mfi_map.svh"
`timescale 1ns/100ps
`default_nettype none
module mfi_input_actions #(
  parameter int NUM_INPUTS = 7
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Terminals and drive status
  input wire logic [NUM_INPUTS-1:0] termIn,
  input wire logic driveStopped,
  input wire logic freqShowsZero,
  // Output stage actions
  output logic outputCoast,
  output logic rampStop,
  output logic faultShow,
  output logic coastShow,
  output logic outputWaiting,
  output logic restartPulse,
  output logic linearRamp,
  output mfi_pkg::mfi_src_t freqSource,
  output logic pidDisable,
  output logic [15:0] freqCmd,
  output logic jogFwd,
  output logic jogRev,
  output logic speedModeForce,
  output logic [15:0] counterValue,
  output logic counterReached,
  output logic irq
);
  import mfi_pkg::*;

  // ==========================================================
  // Parameter check
  if (NUM_INPUTS < 1 || NUM_INPUTS > 8) begin : gBadInputs
    $error("NUM_INPUTS must lie between 1 and 8");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [NUM_INPUTS-1:0][7:0] codes;
    logic termSrc;
    logic torqueMode;
    logic stopCoast;
    logic [2:0] autoRamp;
    logic [15:0] options;
    logic [15:0] upRate;
    logic [15:0] downRate;
    logic [15:0] cntTarget;
    logic [15:0] cntVal;
    logic [15:0] freq;
    logic [15:0] rateCnt;
    logic prevUp;
    logic prevDown;
    logic prevCnt;
    logic prevReached;
    logic resetReq;
    mfi_state_t state;
    logic [3:0] intStat;
    logic [3:0] intMask;
    logic coast;
    logic rStop;
    logic fShow;
    logic cShow;
    logic waiting;
    logic restart;
    logic linear;
    mfi_src_t src;
    logic pidOff;
    logic jFwd;
    logic jRev;
    logic speedForce;
    logic reached;
    logic irq;
    logic ack;
    logic [31:0] dat;
  } mfi_regs_t;

  mfi_regs_t st_reg;
  mfi_regs_t st_next;

  // ==========================================================
  // Functions
  // Any terminal set to a code and on
  function automatic logic funcOn(input logic [NUM_INPUTS-1:0][7:0] codes,
                                  input logic [NUM_INPUTS-1:0] lvl,
                                  input mfi_func_t fn);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (codes[i] == fn && lvl[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Byte-lane merge for writes
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // Decoded terminal functions
  logic faultIn, coastIn, pauseIn, linearIn, anaOneIn, anaTwoIn, forceStopIn;
  logic upIn, downIn, pidOffIn, cntClearIn, cntPulseIn, jogFwdIn, jogRevIn;

  // Terminal levels through the code table
  always_comb begin
    faultIn = funcOn(st_reg.codes, termIn, MFI_FN_EXT_FAULT);
    coastIn = funcOn(st_reg.codes, termIn, MFI_FN_COAST);
    pauseIn = funcOn(st_reg.codes, termIn, MFI_FN_PAUSE);
    linearIn = funcOn(st_reg.codes, termIn, MFI_FN_LINEAR);
    anaOneIn = funcOn(st_reg.codes, termIn, MFI_FN_ANA_ONE);
    anaTwoIn = funcOn(st_reg.codes, termIn, MFI_FN_ANA_TWO);
    forceStopIn = funcOn(st_reg.codes, termIn, MFI_FN_FORCE_STOP);
    upIn = funcOn(st_reg.codes, termIn, MFI_FN_UP);
    downIn = funcOn(st_reg.codes, termIn, MFI_FN_DOWN);
    pidOffIn = funcOn(st_reg.codes, termIn, MFI_FN_PID_OFF);
    cntClearIn = funcOn(st_reg.codes, termIn, MFI_FN_CNT_CLEAR);
    cntPulseIn = funcOn(st_reg.codes, termIn, MFI_FN_CNT_PULSE);
    jogFwdIn = funcOn(st_reg.codes, termIn, MFI_FN_JOG_FWD);
    jogRevIn = funcOn(st_reg.codes, termIn, MFI_FN_JOG_REV);
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic req, wr, rd, stepUp, stepDown, clearFreq, autoSel, jogOk;
    logic [31:0] rdData, wrWord;
    logic [3:0] events;
    logic [15:0] rate;
    req = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    rdData = 32'h0000_0000;
    wrWord = 32'h0000_0000;
    events = 4'h0;
    stepUp = 1'b0;
    stepDown = 1'b0;
    rate = 16'h0000;
    clearFreq = 1'b0;
    autoSel = 1'b0;
    jogOk = 1'b0;
    st_next = st_reg;

    // Bus handshake: ack one cycle, dropped the cycle after
    req = wb_cyc_i && wb_stb_i && !st_reg.ack;
    wr = req && wb_we_i;
    rd = req && !wb_we_i;
    st_next.ack = req;
    st_next.resetReq = 1'b0;

    // Read mux
    if (wb_adr_i < (`MFI_CODE_BASE + 8'(NUM_INPUTS * 4))) begin
      rdData = {24'h00_0000, st_reg.codes[wb_adr_i[4:2]]};
    end else begin
      case ({wb_adr_i[7:2], 2'b00})
        `MFI_CTRL: begin
          rdData[`MFI_CTRL_TERM_SRC] = st_reg.termSrc;
          rdData[`MFI_CTRL_TORQUE] = st_reg.torqueMode;
          rdData[`MFI_CTRL_STOP_COAST] = st_reg.stopCoast;
          rdData[`MFI_CTRL_RAMP_HI:`MFI_CTRL_RAMP_LO] = st_reg.autoRamp;
        end
        `MFI_OPTIONS: rdData = {16'h0000, st_reg.options};
        `MFI_UP_RATE: rdData = {16'h0000, st_reg.upRate};
        `MFI_DOWN_RATE: rdData = {16'h0000, st_reg.downRate};
        `MFI_FREQ: rdData = {16'h0000, st_reg.freq};
        `MFI_CNT_TARGET: rdData = {16'h0000, st_reg.cntTarget};
        `MFI_CNT_VALUE: rdData = {16'h0000, st_reg.cntVal};
        `MFI_STATUS: rdData = {16'h0000, st_reg.waiting, st_reg.reached,
                               st_reg.speedForce, st_reg.jRev, st_reg.jFwd,
                               st_reg.pidOff, st_reg.src, st_reg.linear,
                               st_reg.rStop, st_reg.coast, st_reg.fShow,
                               st_reg.cShow, 1'b0, st_reg.state};
        `MFI_INT_STAT: rdData = {28'h000_0000, st_reg.intStat};
        `MFI_INT_MASK: rdData = {28'h000_0000, st_reg.intMask};
        default: rdData = 32'h0000_0000;
      endcase
    end
    if (rd) begin
      st_next.dat = rdData;
    end

    // Register writes
    if (wr) begin
      wrWord = laneMerge(rdData, wb_dat_i, wb_sel_i);
      if (wb_adr_i < (`MFI_CODE_BASE + 8'(NUM_INPUTS * 4))) begin
        st_next.codes[wb_adr_i[4:2]] = wrWord[7:0];
      end else begin
        case ({wb_adr_i[7:2], 2'b00})
          `MFI_CTRL: begin
            st_next.termSrc = wrWord[`MFI_CTRL_TERM_SRC];
            st_next.torqueMode = wrWord[`MFI_CTRL_TORQUE];
            st_next.stopCoast = wrWord[`MFI_CTRL_STOP_COAST];
            st_next.autoRamp = wrWord[`MFI_CTRL_RAMP_HI:`MFI_CTRL_RAMP_LO];
            st_next.resetReq = wb_sel_i[1] && wb_dat_i[`MFI_CTRL_FAULT_RST];
          end
          `MFI_OPTIONS: st_next.options = wrWord[15:0];
          `MFI_UP_RATE: st_next.upRate = wrWord[15:0];
          `MFI_DOWN_RATE: st_next.downRate = wrWord[15:0];
          `MFI_CNT_TARGET: st_next.cntTarget = wrWord[15:0];
          `MFI_INT_MASK: st_next.intMask = wrWord[3:0];
          default: st_next.intMask = st_reg.intMask;
        endcase
      end
    end

    // Drive sequencing: fault over pause
    st_next.restart = 1'b0;
    case (st_reg.state)
      MFI_DS_RUN: begin
        if (faultIn) begin
          st_next.state = MFI_DS_FAULT;
          events[`MFI_INT_FAULT] = 1'b1;
        end else if (pauseIn) begin
          st_next.state = MFI_DS_PAUSE;
        end
      end
      MFI_DS_FAULT: begin
        if (!faultIn && st_reg.resetReq) begin
          st_next.state = MFI_DS_RUN;
        end
      end
      MFI_DS_PAUSE: begin
        if (faultIn) begin
          st_next.state = MFI_DS_FAULT;
          events[`MFI_INT_FAULT] = 1'b1;
        end else if (!pauseIn) begin
          st_next.state = MFI_DS_RUN;
          st_next.restart = 1'b1;
          events[`MFI_INT_RESTART] = 1'b1;
        end
      end
      default: st_next.state = MFI_DS_RUN;
    endcase

    // Output stage actions
    st_next.fShow = (st_next.state == MFI_DS_FAULT);
    st_next.cShow = coastIn;
    st_next.waiting = (st_next.state == MFI_DS_PAUSE);
    st_next.coast = coastIn || st_next.waiting ||
                    ((st_next.fShow || forceStopIn) && st_reg.stopCoast);
    st_next.rStop = (st_next.fShow || forceStopIn) && !st_reg.stopCoast;
    if (coastIn && !st_reg.cShow) begin
      events[`MFI_INT_COAST] = 1'b1;
    end

    // Auto ramp cancel
    autoSel = (st_reg.autoRamp >= `MFI_RAMP_AUTO_MIN) &&
              (st_reg.autoRamp <= `MFI_RAMP_AUTO_MAX);
    st_next.linear = !autoSel || linearIn;
    // Forced frequency source
    if (anaOneIn) begin
      st_next.src = MFI_SRC_ANA_ONE;
    end else if (anaTwoIn) begin
      st_next.src = MFI_SRC_ANA_TWO;
    end else begin
      st_next.src = MFI_SRC_NORMAL;
    end

    st_next.pidOff = pidOffIn;
    // Up/down frequency stepping
    st_next.prevUp = upIn;
    st_next.prevDown = downIn;
    rate = upIn ? st_reg.upRate : st_reg.downRate;
    if (upIn != downIn) begin
      if ((upIn && !st_reg.prevUp) || (downIn && !st_reg.prevDown)) begin
        stepUp = upIn;
        stepDown = downIn;
        st_next.rateCnt = 16'h0000;
      end else if (st_reg.rateCnt + 16'h0001 >= rate) begin
        stepUp = upIn;
        stepDown = downIn;
        st_next.rateCnt = 16'h0000;
      end else begin
        st_next.rateCnt = st_reg.rateCnt + 16'h0001;
      end
    end else begin
      st_next.rateCnt = 16'h0000;
    end
    clearFreq = driveStopped &&
                (freqShowsZero || st_reg.options[`MFI_OPT_NO_RETAIN]);
    if (clearFreq) begin
      st_next.freq = 16'h0000;
    end else if (stepUp && st_reg.freq != `MFI_FREQ_MAX) begin
      st_next.freq = st_reg.freq + 16'h0001;
    end else if (stepDown && st_reg.freq != 16'h0000) begin
      st_next.freq = st_reg.freq - 16'h0001;
    end

    // Pulse counter
    st_next.prevCnt = cntPulseIn;
    if (cntClearIn) begin
      st_next.cntVal = 16'h0000;
    end else if (cntPulseIn && !st_reg.prevCnt && st_reg.cntVal != 16'hffff) begin
      st_next.cntVal = st_reg.cntVal + 16'h0001;
    end
    st_next.reached = (st_next.cntVal >= st_reg.cntTarget);
    st_next.prevReached = st_next.reached;
    if (st_next.reached && !st_reg.prevReached) begin
      events[`MFI_INT_REACHED] = 1'b1;
    end
    // Jog with torque to speed switch
    jogOk = st_reg.termSrc && (st_next.state == MFI_DS_RUN);
    st_next.jFwd = jogOk && jogFwdIn;
    st_next.jRev = jogOk && jogRevIn && !jogFwdIn;
    st_next.speedForce = st_reg.torqueMode && (st_next.jFwd || st_next.jRev);
    // Sticky interrupts, set wins over read clear
    if (rd && {wb_adr_i[7:2], 2'b00} == `MFI_INT_STAT) begin
      st_next.intStat = events;
    end else begin
      st_next.intStat = st_reg.intStat | events;
    end
    st_next.irq = |(st_next.intStat & st_next.intMask);
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.upRate <= `MFI_RST_RATE;
      st_reg.downRate <= `MFI_RST_RATE;
      st_reg.cntTarget <= `MFI_RST_TARGET;
      st_reg.linear <= 1'b1;
      st_reg.state <= MFI_DS_RUN;
      st_reg.src <= MFI_SRC_NORMAL;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;
  assign outputCoast = st_reg.coast;
  assign rampStop = st_reg.rStop;
  assign faultShow = st_reg.fShow;
  assign coastShow = st_reg.cShow;
  assign outputWaiting = st_reg.waiting;
  assign restartPulse = st_reg.restart;
  assign linearRamp = st_reg.linear;
  assign freqSource = st_reg.src;
  assign pidDisable = st_reg.pidOff;
  assign freqCmd = st_reg.freq;
  assign jogFwd = st_reg.jFwd;
  assign jogRev = st_reg.jRev;
  assign speedModeForce = st_reg.speedForce;
  assign counterValue = st_reg.cntVal;
  assign counterReached = st_reg.reached;
  assign irq = st_reg.irq;
endmodule // mfi_input_actions
`default_nettype wire

/* File: design/mfi_input_actions_end.sv */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* File: design/mfi_map.svh */
/*
 Register offsets, field positions, reset values and timing counts of the
 multi-function input action block. Assumes byte addresses on Wishbone.
*/
`ifndef MFI_MAP_SVH
`define MFI_MAP_SVH
// ==========================================================
// Register byte offsets
`define MFI_CODE_BASE 8'h00
`define MFI_CTRL 8'h20
`define MFI_OPTIONS 8'h24
`define MFI_UP_RATE 8'h28
`define MFI_DOWN_RATE 8'h2c
`define MFI_FREQ 8'h30
`define MFI_CNT_TARGET 8'h34
`define MFI_CNT_VALUE 8'h38
`define MFI_STATUS 8'h3c
`define MFI_INT_STAT 8'h40
`define MFI_INT_MASK 8'h44
// ==========================================================
// Control register fields
`define MFI_CTRL_TERM_SRC 0
`define MFI_CTRL_TORQUE 1
`define MFI_CTRL_STOP_COAST 2
`define MFI_CTRL_RAMP_LO 4
`define MFI_CTRL_RAMP_HI 6
`define MFI_CTRL_FAULT_RST 8
// Options word: up/down value not retained
`define MFI_OPT_NO_RETAIN 7
// ==========================================================
// Interrupt bits
`define MFI_INT_FAULT 0
`define MFI_INT_REACHED 1
`define MFI_INT_RESTART 2
`define MFI_INT_COAST 3
// ==========================================================
// Reset values and timing counts
`define MFI_RST_RATE 16'h00fa
`define MFI_RST_TARGET 16'h0064
`define MFI_FREQ_MAX 16'hffff
`define MFI_RAMP_AUTO_MIN 3'h1
`define MFI_RAMP_AUTO_MAX 3'h4
`endif

/* File: design/mfi_pkg.sv */
/*
 Types of the multi-function input action block: setting codes and
 drive states. Assumes nothing of its surroundings.
*/
`default_nettype none
package mfi_pkg;
  // Setting codes of a digital input terminal
  typedef enum logic [7:0] {
    MFI_FN_EXT_FAULT = 8'h0a,
    MFI_FN_COAST = 8'h0b,
    MFI_FN_PAUSE = 8'h0c,
    MFI_FN_LINEAR = 8'h0d,
    MFI_FN_ANA_ONE = 8'h0f,
    MFI_FN_ANA_TWO = 8'h10,
    MFI_FN_FORCE_STOP = 8'h12,
    MFI_FN_UP = 8'h13,
    MFI_FN_DOWN = 8'h14,
    MFI_FN_PID_OFF = 8'h15,
    MFI_FN_CNT_CLEAR = 8'h16,
    MFI_FN_CNT_PULSE = 8'h17,
    MFI_FN_JOG_FWD = 8'h18,
    MFI_FN_JOG_REV = 8'h19
  } mfi_func_t;
  // Drive sequencing states
  typedef enum logic [1:0] {
    MFI_DS_RUN = 2'b00,
    MFI_DS_FAULT = 2'b01,
    MFI_DS_PAUSE = 2'b10
  } mfi_state_t;
  // Analog source selection
  typedef enum logic [1:0] {
    MFI_SRC_NORMAL = 2'b00,
    MFI_SRC_ANA_ONE = 2'b01,
    MFI_SRC_ANA_TWO = 2'b10
  } mfi_src_t;
endpackage
`default_nettype wire

/* File: verification/mfi_input_actions_assertions.sv */
/*
 Checker of the multi-function input action block, watching its ports.
 Assumes one clock domain with an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module mfi_input_actions_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Drive status and actions
  input wire logic driveStopped,
  input wire logic freqShowsZero,
  input wire logic outputCoast,
  input wire logic rampStop,
  input wire logic faultShow,
  input wire logic coastShow,
  input wire logic outputWaiting,
  input wire logic restartPulse,
  input wire logic jogFwd,
  input wire logic jogRev,
  input wire logic speedModeForce,
  input wire logic [15:0] freqCmd,
  input wire logic [15:0] counterValue,
  input wire mfi_pkg::mfi_src_t freqSource
);
  import mfi_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Bus answer
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_latency: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  // ==========================================================
  // Terminal actions
  a_fault_stops: assert property (faultShow |-> (outputCoast || rampStop))
    else $error("fault shown without stopping");
  a_coast_cuts: assert property (coastShow |-> outputCoast)
    else $error("coast shown with output on");
  a_pause_coasts: assert property (outputWaiting |-> outputCoast)
    else $error("waiting with output on");
  a_restart_once: assert property (restartPulse |-> ($past(outputWaiting) && !outputWaiting) ##1 !restartPulse)
    else $error("restart pulse misplaced");
  a_source_legal: assert property (freqSource != 2'b11)
    else $error("illegal frequency source");
  a_freq_step: assert property ((freqCmd != $past(freqCmd)) |-> (freqCmd == 16'h0000 ||
    freqCmd == $past(freqCmd) + 16'h0001 || freqCmd == $past(freqCmd) - 16'h0001))
    else $error("frequency moved by more than one unit");
  a_freq_zero: assert property ((driveStopped && freqShowsZero) |=> freqCmd == 16'h0000)
    else $error("frequency not cleared when stopped");
  a_count_step: assert property ((counterValue != $past(counterValue)) |->
    (counterValue == 16'h0000 || counterValue == $past(counterValue) + 16'h0001))
    else $error("counter moved by more than one");
  a_jog_exclusive: assert property (jogFwd |-> !jogRev)
    else $error("both jog directions active");
  a_speed_for_jog: assert property (speedModeForce |-> (jogFwd || jogRev))
    else $error("speed mode forced without jog");
endmodule // mfi_input_actions_checker
bind mfi_input_actions mfi_input_actions_checker u_mfi_input_actions_checker (
  .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .driveStopped(driveStopped), .freqShowsZero(freqShowsZero),
  .outputCoast(outputCoast), .rampStop(rampStop), .faultShow(faultShow),
  .coastShow(coastShow), .outputWaiting(outputWaiting), .restartPulse(restartPulse),
  .jogFwd(jogFwd), .jogRev(jogRev), .speedModeForce(speedModeForce), .freqCmd(freqCmd),
  .counterValue(counterValue), .freqSource(freqSource));
`default_nettype wire

/* File: verification/mfi_switch_bank.sv */
/*
 Bank of external switches and contacts on the digital input terminals.
 Assumes the bench sets the contact positions just after a clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module mfi_switch_bank #(
  parameter int NUM_INPUTS = 7
) (
  // Contact positions wanted by the bench
  input wire logic [NUM_INPUTS-1:0] closeReq,
  // Terminal levels, high while closed
  output logic [NUM_INPUTS-1:0] termIn
);
  // Closed contacts pull their terminal on, open ones leave it off
  assign termIn = closeReq;
endmodule // mfi_switch_bank
`default_nettype wire

/* File: verification/tb.sv */
/*
 Self-checking bench of the multi-function input action block.
 Assumes the design, its package and the switch bank model are compiled first.
*/
`include "mfi_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  import mfi_pkg::*;
  logic core_clk, arst_n, wbCyc, wbStb, wbWe, driveStopped, freqShowsZero;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, rd;
  logic wbAck, outputCoast, rampStop, faultShow, coastShow, outputWaiting, restartPulse;
  logic linearRamp, pidDisable, jogFwd, jogRev, speedModeForce, counterReached, irq;
  mfi_src_t freqSource;
  logic [15:0] freqCmd, counterValue;
  logic [6:0] sw, termIn;
  logic [10:0] flags;
  logic [18:0] rows [9];
  int n_fail = 0, checks_done = 0, cycles = 0;
  assign flags = {outputCoast, rampStop, coastShow, outputWaiting, linearRamp, freqSource,
    pidDisable, jogFwd, jogRev, irq};
  // ==========================================================
  // Design, switches and clock
  mfi_input_actions u_mfi_input_actions (.core_clk(core_clk), .arst_n(arst_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .termIn(termIn),
    .driveStopped(driveStopped), .freqShowsZero(freqShowsZero), .outputCoast(outputCoast),
    .rampStop(rampStop), .faultShow(faultShow), .coastShow(coastShow),
    .outputWaiting(outputWaiting), .restartPulse(restartPulse), .linearRamp(linearRamp),
    .freqSource(freqSource), .pidDisable(pidDisable), .freqCmd(freqCmd), .jogFwd(jogFwd),
    .jogRev(jogRev), .speedModeForce(speedModeForce), .counterValue(counterValue),
    .counterReached(counterReached), .irq(irq));
  mfi_switch_bank u_mfi_switch_bank (.closeReq(sw), .termIn(termIn));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    do @(posedge core_clk); while (wbAck !== 1'b1);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic press(input int idx, input int n);
    sw[idx] <= 1'b1;
    tick(n);
    sw[idx] <= 1'b0;
    tick(3);
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    {wbCyc, wbStb, wbWe, driveStopped, freqShowsZero} = 5'h00;
    {wbAdr, wbDatW, sw} = '0;
    wbSel = 4'hf;
    rows = '{{8'h0b, 11'h500}, {8'h0c, 11'h480}, {8'h0d, 11'h040}, {8'h0f, 11'h010},
      {8'h10, 11'h020}, {8'h12, 11'h200}, {8'h15, 11'h008}, {8'h18, 11'h004}, {8'h19, 11'h002}};
    tick(12);
    check({31'h0, linearRamp}, 32'h1);
    arst_n <= 1'b1;
    // Reset values and an unmapped place
    wb(1'b0, `MFI_UP_RATE, 32'h0);
    check(rd, 32'h00fa);
    wb(1'b0, `MFI_CNT_TARGET, 32'h0);
    check(rd, 32'h0064);
    wb(1'b0, 8'h50, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, `MFI_CTRL, 32'h0011);
    // Nine codes on terminal zero, on then off
    foreach (rows[i]) begin
      wb(1'b1, `MFI_CODE_BASE, {24'h0, rows[i][18:11]});
      sw[0] <= 1'b1;
      tick(3);
      check({21'h0, flags}, {21'h0, rows[i][10:0]});
      sw[0] <= 1'b0;
      tick(3);
      check({21'h0, flags}, 32'h0);
    end
    // Both analog sources: one wins
    wb(1'b1, `MFI_CODE_BASE, 32'h0f);
    wb(1'b1, `MFI_CODE_BASE + 8'h04, 32'h10);
    sw <= 7'h03;
    tick(3);
    check({30'h0, freqSource}, 32'h1);
    sw <= 7'h00;
    // Fault latches until reset with terminal restored, raises irq
    wb(1'b1, `MFI_CODE_BASE + 8'h04, 32'h0a);
    wb(1'b1, `MFI_INT_MASK, 32'h1);
    wb(1'b0, `MFI_INT_STAT, 32'h0);
    sw[1] <= 1'b1;
    tick(3);
    check({29'h0, faultShow, rampStop, irq}, 32'h7);
    sw[1] <= 1'b0;
    tick(3);
    check({31'h0, faultShow}, 32'h1);
    wb(1'b0, `MFI_INT_STAT, 32'h0);
    check(rd & 32'h1, 32'h1);
    tick(2);
    check({31'h0, irq}, 32'h0);
    wb(1'b1, `MFI_CTRL, 32'h0111);
    tick(4);
    check({30'h0, faultShow, rampStop}, 32'h0);
    // Up and down stepping
    wb(1'b1, `MFI_CODE_BASE + 8'h08, 32'h13);
    wb(1'b1, `MFI_CODE_BASE + 8'h0c, 32'h14);
    wb(1'b1, `MFI_UP_RATE, 32'h4);
    press(2, 1);
    press(2, 1);
    press(3, 1);
    check({16'h0, freqCmd}, 32'h1);
    press(2, 41);
    check({16'h0, freqCmd}, 32'hc);
    wb(1'b1, `MFI_DOWN_RATE, 32'h2);
    press(3, 5);
    check({16'h0, freqCmd}, 32'h9);
    driveStopped <= 1'b1;
    tick(3);
    check({31'h0, freqCmd != 16'h0}, 32'h1);
    freqShowsZero <= 1'b1;
    tick(3);
    check({16'h0, freqCmd}, 32'h0);
    {driveStopped, freqShowsZero} <= 2'b00;
    wb(1'b1, `MFI_OPTIONS, 32'h80);
    press(2, 1);
    driveStopped <= 1'b1;
    tick(3);
    check({16'h0, freqCmd}, 32'h0);
    driveStopped <= 1'b0;
    // Counter: held level counts once, clear holds zero
    wb(1'b1, `MFI_CODE_BASE + 8'h10, 32'h17);
    wb(1'b1, `MFI_CODE_BASE + 8'h14, 32'h16);
    wb(1'b1, `MFI_CNT_TARGET, 32'h2);
    press(4, 5);
    check({16'h0, counterValue}, 32'h1);
    press(4, 1);
    check({15'h0, counterReached, counterValue}, 32'h10002);
    sw[5] <= 1'b1;
    press(4, 1);
    check({16'h0, counterValue}, 32'h0);
    sw[5] <= 1'b0;
    press(4, 1);
    check({16'h0, counterValue}, 32'h1);
    // Pause release restarts once; coast stop method on force stop
    wb(1'b1, `MFI_CODE_BASE + 8'h18, 32'h0c);
    sw[6] <= 1'b1;
    tick(3);
    sw[6] <= 1'b0;
    tick(2);
    check({31'h0, restartPulse}, 32'h1);
    tick(1);
    check({31'h0, restartPulse}, 32'h0);
    wb(1'b0, `MFI_INT_STAT, 32'h0);
    check(rd & 32'h4, 32'h4);
    wb(1'b1, `MFI_CODE_BASE + 8'h18, 32'h12);
    wb(1'b1, `MFI_CTRL, 32'h0015);
    sw[6] <= 1'b1;
    tick(3);
    check({30'h0, outputCoast, rampStop}, 32'h2);
    sw[6] <= 1'b0;
    // Jog in torque mode, then from a non-terminal source
    wb(1'b1, `MFI_CODE_BASE, 32'h19);
    wb(1'b1, `MFI_CTRL, 32'h0013);
    sw[0] <= 1'b1;
    tick(3);
    check({30'h0, jogRev, speedModeForce}, 32'h3);
    sw[0] <= 1'b0;
    tick(3);
    check({30'h0, jogRev, speedModeForce}, 32'h0);
    wb(1'b1, `MFI_CTRL, 32'h0012);
    press(0, 3);
    sw[0] <= 1'b1;
    tick(3);
    check({31'h0, jogRev}, 32'h0);
    sw[0] <= 1'b0;
    tick(2);
    // Reset in mid-run restores outputs and registers
    arst_n <= 1'b0;
    tick(2);
    check({15'h0, linearRamp, counterValue}, 32'h10000);
    arst_n <= 1'b1;
    wb(1'b0, `MFI_CNT_TARGET, 32'h0);
    check(rd, 32'h0064);
    finish_test();
  end
endmodule // tb
`default_nettype wire
